// ===== design/bcr_defs.vh
// constants of the converter control register bank
`ifndef BCR_DEFS_VH
`define BCR_DEFS_VH
`define BCR_ADDR_OPCTL 8'h14
`define BCR_ADDR_STAGE 8'h15
`define BCR_ADDR_LIMIT 8'h16
`define BCR_RST_OPCTL 8'h00
`define BCR_RST_STAGE 8'h80
`define BCR_RST_LIMIT 8'h02
`define BCR_OPCTL_MASK 8'hf1
`define BCR_STAGE_MASK 8'hf0
`define BCR_BIT_LOW_PWM 7
`define BCR_BIT_HIGH_PWM 6
`define BCR_BIT_RAMP 5
`define BCR_BIT_SLEEP 4
`define BCR_BIT_GATING 0
`define BCR_BIT_RELOAD 2
`define BCR_BIT_INDIC 1
`define BCR_BIT_RESTART 0
`define BCR_STAGE_MAX 4'h8
`endif

// ===== design/bcr_sync.v
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none
module bcr_sync #(
  parameter WIDTH = 1
) (
  input wire i_clk,
  input wire i_rstn,
  input wire [WIDTH-1:0] i_async,
  output reg [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta;

  // first stage is read only by the second
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta <= {WIDTH{1'b0}};
      o_sync <= {WIDTH{1'b0}};
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule
`default_nettype wire

// ===== design/bcr_regs.v
// control register bank of the step-down converter
`timescale 1ns/1ps
`default_nettype none
`include "bcr_defs.vh"
module bcr_regs (
  input wire i_ref_clk,
  input wire i_rstn,
  input wire i_wr_en,
  input wire i_rd_en,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_enable_pin,
  input wire i_select_pin,
  input wire i_ramp_active,
  input wire i_thermal_shutdown,
  output reg [7:0] o_rdata,
  output reg o_rd_valid,
  output reg o_select_internal,
  output reg o_forced_pwm,
  output reg o_sleep_forced,
  output reg o_low_quiescent,
  output reg [3:0] o_stage_count,
  output reg [8:0] o_stage_enable,
  output reg [1:0] o_coil_current_limit,
  output reg [1:0] o_thermal_prewarn_level,
  output reg o_power_on,
  output reg o_restart_pulse
);
  // -----------------------------------------------------------------
  // reset release and pin synchronisation
  // -----------------------------------------------------------------
  reg [1:0] rst_pipe;
  wire rstn = rst_pipe[1];
  wire [2:0] pins_s;

  // reset applied at once, released two edges after the pin
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  // pins cross into the clock domain here
  bcr_sync #(.WIDTH(3)) u_sync (
    .i_clk(i_ref_clk),
    .i_rstn(rstn),
    .i_async({i_thermal_shutdown, i_select_pin, i_enable_pin}),
    .o_sync(pins_s)
  );

  wire en_s = pins_s[0];
  wire sel_s = pins_s[1];
  wire overheat_s = pins_s[2];

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  reg [7:0] opctl;
  reg [7:0] stage;
  reg [7:0] limit;
  reg overheat_prev;

  // clamp codes above eight to nine modules
  function [3:0] bcr_clamp;
    input [3:0] code;
    begin
      bcr_clamp = (code > `BCR_STAGE_MAX) ? `BCR_STAGE_MAX : code;
    end
  endfunction

  // thermometer enable of output stages
  function [8:0] bcr_therm;
    input [3:0] n;
    integer k;
    begin
      for (k = 0; k < 9; k = k + 1) begin
        bcr_therm[k] = (k <= n);
      end
    end
  endfunction

  // one strobe per register; unmapped addresses hit nothing
  wire wr_opctl = i_wr_en && (i_addr == `BCR_ADDR_OPCTL);
  wire wr_stage = i_wr_en && (i_addr == `BCR_ADDR_STAGE);
  wire wr_limit = i_wr_en && (i_addr == `BCR_ADDR_LIMIT);
  // reload takes the whole bank back to defaults, data ignored
  wire reload = wr_limit && i_wdata[`BCR_BIT_RELOAD];

  // register writes; reload restores defaults, indicator set
  always @(posedge i_ref_clk or negedge rstn) begin
    if (!rstn) begin
      opctl <= `BCR_RST_OPCTL;
      stage <= `BCR_RST_STAGE;
      limit <= `BCR_RST_LIMIT;
    end else if (reload) begin
      opctl <= `BCR_RST_OPCTL;
      stage <= `BCR_RST_STAGE;
      limit <= `BCR_RST_LIMIT;
    end else if (i_wr_en) begin
      if (wr_opctl) begin
        opctl <= i_wdata & `BCR_OPCTL_MASK;
      end
      if (wr_stage) begin
        stage <= i_wdata & `BCR_STAGE_MASK;
      end
      if (wr_limit) begin
        // reload bit never stored, so it reads back as 0
        limit <= {i_wdata[7:3], 1'b0, i_wdata[1:0]};
      end
    end
  end

  // read port, unmapped addresses read zero
  always @(posedge i_ref_clk or negedge rstn) begin
    if (!rstn) begin
      o_rdata <= 8'h00;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_en;
      if (!i_rd_en) begin
        o_rdata <= 8'h00;
      end else begin
        case (i_addr)
          `BCR_ADDR_OPCTL: o_rdata <= opctl;
          `BCR_ADDR_STAGE: o_rdata <= stage;
          `BCR_ADDR_LIMIT: o_rdata <= limit;
          default: o_rdata <= 8'h00;
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // operating mode outputs
  // -----------------------------------------------------------------
  wire next_sel = opctl[`BCR_BIT_GATING] & sel_s;
  wire both_low = !en_s && !sel_s;
  reg next_forced_pwm;

  // mode pick; a running ramp overrides the per-select bits
  always @* begin
    next_forced_pwm = opctl[`BCR_BIT_LOW_PWM];
    if (i_ramp_active) begin
      next_forced_pwm = opctl[`BCR_BIT_RAMP];
    end else if (next_sel) begin
      next_forced_pwm = opctl[`BCR_BIT_HIGH_PWM];
    end
  end

  // gated select and the mode it picks
  always @(posedge i_ref_clk or negedge rstn) begin
    if (!rstn) begin
      o_select_internal <= 1'b0;
      o_forced_pwm <= 1'b0;
    end else begin
      o_select_internal <= next_sel;
      o_forced_pwm <= next_forced_pwm;
    end
  end

  // sleep policy only applies while both pins are low
  always @(posedge i_ref_clk or negedge rstn) begin
    if (!rstn) begin
      o_sleep_forced <= 1'b0;
      o_low_quiescent <= 1'b0;
    end else begin
      o_sleep_forced <= both_low && opctl[`BCR_BIT_SLEEP];
      o_low_quiescent <= both_low && !opctl[`BCR_BIT_SLEEP];
    end
  end

  // -----------------------------------------------------------------
  // output stages and limits
  // -----------------------------------------------------------------
  wire [3:0] stage_code = stage[7:4];

  // count and enables share one clamp so they never disagree
  always @(posedge i_ref_clk or negedge rstn) begin
    if (!rstn) begin
      o_stage_count <= 4'h0;
      o_stage_enable <= 9'h000;
    end else begin
      o_stage_count <= bcr_clamp(stage_code);
      o_stage_enable <= bcr_therm(bcr_clamp(stage_code));
    end
  end

  // limit codes passed on as codes; the analog side maps them
  always @(posedge i_ref_clk or negedge rstn) begin
    if (!rstn) begin
      o_coil_current_limit <= 2'b00;
      o_thermal_prewarn_level <= 2'b00;
    end else begin
      o_coil_current_limit <= limit[7:6];
      o_thermal_prewarn_level <= limit[5:4];
    end
  end

  // -----------------------------------------------------------------
  // thermal shutdown and restart
  // -----------------------------------------------------------------
  // end of an overheat spell, seen one cycle after the flag drops
  wire overheat_fall = overheat_prev && !overheat_s;

  // power off while hot; without the restart bit it stays off
  always @(posedge i_ref_clk or negedge rstn) begin
    if (!rstn) begin
      overheat_prev <= 1'b0;
      o_power_on <= 1'b1;
      o_restart_pulse <= 1'b0;
    end else begin
      overheat_prev <= overheat_s;
      o_restart_pulse <= 1'b0;
      if (overheat_s) begin
        o_power_on <= 1'b0;
      end else if (overheat_fall && limit[`BCR_BIT_RESTART]) begin
        // registers kept, new power-up started
        o_power_on <= 1'b1;
        o_restart_pulse <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== testbench/bcr_regs_chk.sv
// assertions on the register bank ports
`timescale 1ns/1ps
`default_nettype none
module bcr_regs_chk (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_addr,
  input wire logic i_select_pin,
  input wire logic i_thermal_shutdown,
  input wire logic [7:0] o_rdata,
  input wire logic o_rd_valid,
  input wire logic o_select_internal,
  input wire logic o_sleep_forced,
  input wire logic o_low_quiescent,
  input wire logic [3:0] o_stage_count,
  input wire logic [8:0] o_stage_enable,
  input wire logic o_power_on,
  input wire logic o_restart_pulse
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  a_stage_therm: assert property (o_stage_enable[0] |->
    o_stage_enable == 9'h1ff >> (4'h8 - o_stage_count)) else $error("stages");
  a_count_max: assert property (o_stage_count <= 4'h8)
    else $error("count");
  a_sleep_excl: assert property (!(o_sleep_forced && o_low_quiescent))
    else $error("sleep");
  a_select_gate: assert property (o_select_internal |->
    $past(i_select_pin, 3)) else $error("select");
  a_power_drop: assert property ($rose(i_thermal_shutdown) |->
    ##[1:4] !o_power_on) else $error("power");
  a_restart_once: assert property (o_restart_pulse |=>
    !o_restart_pulse && o_power_on) else $error("restart");
  a_reload_self: assert property (o_rd_valid && $past(i_addr) == 8'h16
    |-> !o_rdata[2]) else $error("reload");
  a_spare_zero: assert property (o_rd_valid && $past(i_addr) == 8'h15
    |-> o_rdata[3:0] == 4'h0) else $error("spare");
endmodule
`default_nettype wire

// ===== testbench/bcr_host.sv
// host model issuing register writes and reads
`timescale 1ns/1ps
`default_nettype none
module bcr_host (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic o_wr = 0,
  output logic o_rd = 0,
  output logic [7:0] o_addr = 8'h00,
  output logic [7:0] o_wdata = 8'h00
);
  // one write, strobe held over one rising edge
  task wr(input [7:0] a, input [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1;
    @(negedge i_clk);
    o_wr = 0;
    o_wdata = ~d;
  endtask
  // one read, data taken in the answer cycle
  task rd(input [7:0] a, output [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1;
    @(negedge i_clk);
    o_rd = 0;
    d = i_rdata;
  endtask
endmodule
`default_nettype wire

// ===== testbench/bcr_regs_tb_top.sv
// testbench for the converter control register bank
`timescale 1ns/1ps
`default_nettype none
module bcr_regs_tb_top;
  logic clk = 0, rstn = 0, en = 1, sel = 0, ramp = 0, hot = 0;
  logic wr, rden, vld, seli, pwm, slp, lq, pwr;
  logic [7:0] rd, rdat, addr, wdat;
  logic [3:0] cnt;
  logic [8:0] stg;
  logic [1:0] lim, tpw;
  int err_total = 0, n_compared = 0, cyc = 0, i;
  logic [23:0] rt [7] = '{24'h14_fff1, 24'h15_fff0, 24'h15_3030,
    24'h16_f1f1, 24'h20_5500, 24'h13_5500, 24'h17_aa00};
  logic [15:0] mt [7] = '{16'h8168, 16'h416c, 16'h4060, 16'h8064,
    16'h2054, 16'h1002, 16'h0001};
  bcr_regs u_dut (.i_ref_clk(clk), .i_rstn(rstn), .i_wr_en(wr),
    .i_rd_en(rden), .i_addr(addr), .i_wdata(wdat), .i_enable_pin(en),
    .i_select_pin(sel), .i_ramp_active(ramp), .i_thermal_shutdown(hot),
    .o_rdata(rdat), .o_rd_valid(vld), .o_select_internal(seli),
    .o_forced_pwm(pwm), .o_sleep_forced(slp), .o_low_quiescent(lq),
    .o_stage_count(cnt), .o_stage_enable(stg), .o_coil_current_limit(lim),
    .o_thermal_prewarn_level(tpw), .o_power_on(pwr), .o_restart_pulse());
  bcr_host u_host (.i_clk(clk), .i_rdata(rdat), .o_wr(wr), .o_rd(rden),
    .o_addr(addr), .o_wdata(wdat));
  task chk(input [15:0] g, input [15:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task rchk(input [7:0] a, input [7:0] e);
    u_host.rd(a, rd);
    chk(rd, e);
  endtask
  task end_sim;
    $display("compared %0d wrong %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // clock and hang limit
  always #20 clk = ~clk;
  always @(posedge clk) begin
    if (++cyc == 5000) begin
      err_total++;
      end_sim;
    end
  end
  initial begin
    repeat (20) @(negedge clk);
    rstn = 1;
    repeat (4) @(negedge clk);
    rchk(8'h14, 8'h00);
    rchk(8'h15, 8'h80);
    rchk(8'h16, 8'h02);
    for (i = 0; i < 7; i++) begin
      u_host.wr(rt[i][23:16], rt[i][15:8]);
      rchk(rt[i][23:16], rt[i][7:0]);
    end
    for (i = 0; i < 7; i++) begin
      u_host.wr(8'h14, mt[i][15:8]);
      {en, sel, ramp} = mt[i][6:4];
      repeat (4) @(negedge clk);
      chk({seli, pwm, slp, lq}, mt[i][3:0]);
    end
    en = 1;
    for (i = 0; i < 16; i++) begin
      u_host.wr(8'h15, {i[3:0], 4'h0});
      repeat (2) @(negedge clk);
      chk(cnt, (i > 8) ? 16'h0008 : i[15:0]);
      chk(stg, 16'h01ff >> (8 - ((i > 8) ? 8 : i)));
    end
    for (i = 0; i < 4; i++) begin
      u_host.wr(8'h16, {i[1:0], ~i[1:0], 4'h0});
      repeat (2) @(negedge clk);
      chk({lim, tpw}, {i[1:0], ~i[1:0]});
    end
    $display("tables done");
    u_host.wr(8'h14, 8'hf1);
    u_host.wr(8'h15, 8'h50);
    u_host.wr(8'h16, 8'hfd);
    rchk(8'h16, 8'h02);
    rchk(8'h15, 8'h80);
    rchk(8'h14, 8'h00);
    for (i = 0; i < 2; i++) begin
      u_host.wr(8'h16, {7'h00, i[0]});
      hot = 1;
      repeat (6) @(negedge clk);
      hot = 0;
      repeat (8) @(negedge clk);
      chk(pwr, i[15:0]);
    end
    rchk(8'h16, 8'h01);
    $display("reload and overheat done");
    rstn = 0;
    repeat (3) @(negedge clk);
    rstn = 1;
    repeat (4) @(negedge clk);
    rchk(8'h16, 8'h02);
    rchk(8'h15, 8'h80);
    $display("second reset done");
    end_sim;
  end
endmodule
bind bcr_regs bcr_regs_chk u_chk (.*);
`default_nettype wire
